// *** src/lsce_pkg.sv ***
// constants and types for the link status and channel enable register block
package lsce_pkg;
    localparam int unsigned LSCE_ADDR_W = 12;
    localparam logic [11:0] LSCE_OFS_STATUS = 12'h208;
    localparam logic [11:0] LSCE_OFS_CHEN = 12'h209;
    localparam logic [7:0] LSCE_CHEN_RESET = 8'h03;
    localparam logic [7:0] LSCE_STATUS_RESET = 8'h00;
    // status bit positions
    localparam int unsigned LSCE_ST_SAMPLING_LOCK = 0;
    localparam int unsigned LSCE_ST_SERIAL_LOCK = 2;
    localparam int unsigned LSCE_ST_PHASE_SET = 3;
    localparam int unsigned LSCE_ST_REALIGNED = 4;
    localparam int unsigned LSCE_ST_LINE = 5;
    localparam int unsigned LSCE_ST_LINK_UP = 6;
    // channel enable bit positions
    localparam int unsigned LSCE_CE_FIRST = 0;
    localparam int unsigned LSCE_CE_SECOND = 1;
    localparam int unsigned LSCE_CE_ONE_CH = 2;
    // full-mode link shape defaults
    localparam int unsigned LSCE_LANES_FULL = 8;
    localparam int unsigned LSCE_CONV_FULL = 4;
    typedef enum logic [1:0] {
        LSCE_PLACE_NORMAL = 2'b00,
        LSCE_PLACE_SHIFTED = 2'b01
    } lsce_place_t;
endpackage

// *** src/lsce_sticky.sv ***
`timescale 1ns/1ns
// sticky flag: hardware set, write-one clear, set wins
module lsce_sticky (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // set and clear
    input wire logic set_i,
    input wire logic clr_i,
    // flag
    output logic flag_o
);
    logic flag_q;
    logic flag_d;
    assign flag_d = set_i ? 1'b1 : (clr_i ? 1'b0 : flag_q);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end
    assign flag_o = flag_q;

    set_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        set_i |=> flag_o)
        else $error("sticky flag lost a set");
endmodule

// *** src/lsce_top.sv ***
`timescale 1ns/1ns
module lsce_top
    import lsce_pkg::*;
#(
    parameter int unsigned LANES_FULL = LSCE_LANES_FULL,
    parameter int unsigned CONV_FULL = LSCE_CONV_FULL
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // register port
    input wire logic [LSCE_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // live state from the link and clocking
    input wire logic sync_line_n,
    input wire logic sysref_realign,
    input wire logic sysref_event,
    input wire logic serial_link_enable_bit,
    input wire logic serializer_pll_lock,
    input wire logic sampling_pll_lock,
    input wire logic link_up,
    // channel control outputs
    output logic chan_a_en,
    output logic chan_b_en,
    output logic chan_c_en,
    output logic chan_d_en,
    output logic one_channel_mode,
    output logic [7:0] link_lanes,
    output logic [7:0] link_converters,
    output logic tail_pad_en,
    output logic sample_place_shift
);
    // reset release
    logic rst_s1_q;
    logic rst_n;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rst_s1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n <= rst_s1_q;
        end
    end

    // address decode
    wire sel_status = (reg_addr == LSCE_OFS_STATUS);
    wire sel_chen = (reg_addr == LSCE_OFS_CHEN);
    wire wr_status = reg_wr && sel_status;
    wire wr_chen = reg_wr && sel_chen;

    // channel enable register; reserved bits stored as written
    logic [7:0] chen_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chen_q <= LSCE_CHEN_RESET;
        end else if (wr_chen) begin
            chen_q <= reg_wdata;
        end
    end

    // first sysref after encoder enable; disarmed while the link is disabled, re-armed each time the encoder is enabled again
    logic enc_armed_q;
    logic enc_en_prev_q;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            enc_armed_q <= 1'b0;
            enc_en_prev_q <= 1'b0;
        end else begin
            enc_en_prev_q <= serial_link_enable_bit;
            if (!serial_link_enable_bit) begin
                enc_armed_q <= 1'b0;
            end else if (!enc_en_prev_q) begin
                enc_armed_q <= 1'b1;
            end else if (sysref_event) begin
                enc_armed_q <= 1'b0;
            end
        end
    end
    wire phase_set_evt = enc_armed_q && enc_en_prev_q && serial_link_enable_bit && sysref_event;

    // sticky flags
    logic realigned_flag;
    logic multiframe_phase_set_flag;
    lsce_sticky u_realign (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set_i(sysref_realign),
        .clr_i(wr_status && reg_wdata[LSCE_ST_REALIGNED]),
        .flag_o(realigned_flag)
    );
    lsce_sticky u_phase (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .set_i(phase_set_evt),
        .clr_i(wr_status && reg_wdata[LSCE_ST_PHASE_SET]),
        .flag_o(multiframe_phase_set_flag)
    );

    // live status bits are not writable, so writes only reach the sticky pair
    wire serializer_pll_lock_flag = serializer_pll_lock;
    wire sampling_pll_lock_flag = sampling_pll_lock;
    logic [7:0] status_w;
    always_comb begin
        status_w = LSCE_STATUS_RESET;
        status_w[LSCE_ST_LINK_UP] = link_up;
        status_w[LSCE_ST_LINE] = sync_line_n;
        status_w[LSCE_ST_REALIGNED] = realigned_flag;
        status_w[LSCE_ST_PHASE_SET] = multiframe_phase_set_flag;
        status_w[LSCE_ST_SERIAL_LOCK] = serializer_pll_lock_flag;
        status_w[LSCE_ST_SAMPLING_LOCK] = sampling_pll_lock_flag;
    end

    // read data, valid the cycle after the strobe
    wire [7:0] rd_mux = sel_status ? status_w : (sel_chen ? chen_q : 8'h00);
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // channel enables
    wire first_pair_enable = chen_q[LSCE_CE_FIRST];
    wire second_pair_enable = chen_q[LSCE_CE_SECOND];
    wire one_ch = chen_q[LSCE_CE_ONE_CH];
    wire pair_off = !(first_pair_enable && second_pair_enable) || one_ch;

    function automatic logic [7:0] half_up(input int unsigned v);
        half_up = 8'((v + 1) / 2);
    endfunction

    wire [7:0] lanes_d = pair_off ? half_up(LANES_FULL) : 8'(LANES_FULL);
    wire [7:0] conv_d = pair_off ? 8'(CONV_FULL / 2) : 8'(CONV_FULL);
    wire tail_d = pair_off && (LANES_FULL % 2 == 1);
    lsce_place_t place_d;
    assign place_d = first_pair_enable ? LSCE_PLACE_NORMAL : LSCE_PLACE_SHIFTED;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            chan_a_en <= 1'b1;
            chan_b_en <= 1'b1;
            chan_c_en <= 1'b1;
            chan_d_en <= 1'b1;
            one_channel_mode <= 1'b0;
            link_lanes <= 8'h00;
            link_converters <= 8'h00;
            tail_pad_en <= 1'b0;
            sample_place_shift <= 1'b0;
        end else begin
            chan_a_en <= first_pair_enable;
            chan_b_en <= first_pair_enable && !one_ch;
            chan_c_en <= second_pair_enable && !one_ch;
            chan_d_en <= second_pair_enable && !one_ch;
            one_channel_mode <= one_ch;
            link_lanes <= lanes_d;
            link_converters <= conv_d;
            tail_pad_en <= tail_d;
            sample_place_shift <= (place_d == LSCE_PLACE_SHIFTED);
        end
    end

    // checks
    line_state_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status |=> reg_rdata[LSCE_ST_LINE] == $past(sync_line_n))
        else $error("line state read wrong");
    pll_lock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status |=> reg_rdata[LSCE_ST_SERIAL_LOCK] == $past(serializer_pll_lock)
            && reg_rdata[LSCE_ST_SAMPLING_LOCK] == $past(sampling_pll_lock))
        else $error("pll lock read wrong");
    realign_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sysref_realign |=> realigned_flag)
        else $error("realign not flagged");
    clear_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status && reg_wdata[LSCE_ST_PHASE_SET] && !phase_set_evt
            |=> !multiframe_phase_set_flag)
        else $error("phase flag not cleared");
    zero_keeps_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status && !reg_wdata[LSCE_ST_REALIGNED] && realigned_flag |=> realigned_flag)
        else $error("realign flag lost on zero write");
    single_chan_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        one_ch |=> !chan_b_en && !chan_c_en && !chan_d_en)
        else $error("single channel mode leaves channels on");
    pair_scale_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !second_pair_enable |=> link_converters == 8'(CONV_FULL / 2))
        else $error("converter count not halved");
    place_shift_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !first_pair_enable |=> sample_place_shift)
        else $error("sample placement not shifted");
    link_up_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status |=> reg_rdata[LSCE_ST_LINK_UP] == $past(link_up))
        else $error("link up read wrong");

    // reset release: the second stage never runs ahead of the first
    rst_order_a: assert property (@(posedge clk_sys)
        rst_n |-> rst_s1_q)
        else $error("reset stages out of order");

    // channel enable register storage
    chen_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_chen |=> chen_q == $past(reg_wdata))
        else $error("channel enable write lost");
    chen_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !wr_chen |=> $stable(chen_q))
        else $error("channel enable changed without write");
    status_no_chen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status |=> $stable(chen_q))
        else $error("status write reached channel enable");

    // sticky alignment flags
    realign_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status && reg_wdata[LSCE_ST_REALIGNED] && !sysref_realign |=> !realigned_flag)
        else $error("realign flag not cleared");
    phase_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status && !reg_wdata[LSCE_ST_PHASE_SET] && multiframe_phase_set_flag
            |=> multiframe_phase_set_flag)
        else $error("phase flag lost on zero write");
    clear_both_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_status && reg_wdata[LSCE_ST_REALIGNED] && reg_wdata[LSCE_ST_PHASE_SET]
            && !sysref_realign && !phase_set_evt
            |=> !realigned_flag && !multiframe_phase_set_flag)
        else $error("flags not both cleared");
    realign_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sysref_realign && wr_status && reg_wdata[LSCE_ST_REALIGNED] |=> realigned_flag)
        else $error("clear beat a realign event");
    phase_wins_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_set_evt && wr_status && reg_wdata[LSCE_ST_PHASE_SET]
            |=> multiframe_phase_set_flag)
        else $error("clear beat a phase event");
    phase_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_set_evt |=> multiframe_phase_set_flag)
        else $error("phase event not flagged");
    realign_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sysref_realign && !(wr_status && reg_wdata[LSCE_ST_REALIGNED]) |=> $stable(realigned_flag))
        else $error("realign flag moved on its own");
    phase_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !phase_set_evt && !(wr_status && reg_wdata[LSCE_ST_PHASE_SET])
            |=> $stable(multiframe_phase_set_flag))
        else $error("phase flag moved on its own");

    // arming for the first sysref after the encoder comes on
    phase_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !serial_link_enable_bit |-> !phase_set_evt)
        else $error("phase event while encoder off");
    arm_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !serial_link_enable_bit |=> !enc_armed_q)
        else $error("armed while encoder off");
    arm_rise_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        serial_link_enable_bit && !enc_en_prev_q |=> enc_armed_q)
        else $error("not armed on encoder enable");
    arm_once_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        phase_set_evt |=> !enc_armed_q)
        else $error("still armed after first sysref");
    no_rearm_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enc_armed_q && enc_en_prev_q && serial_link_enable_bit |=> !enc_armed_q)
        else $error("re-armed while encoder stays on");

    // read path
    rd_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    rd_unmapped_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && !sel_status && !sel_chen |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    rd_chen_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_chen |=> reg_rdata == $past(chen_q))
        else $error("channel enable read wrong");
    realign_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status |=> reg_rdata[LSCE_ST_REALIGNED] == $past(realigned_flag))
        else $error("realign flag read wrong");
    phase_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status
            |=> reg_rdata[LSCE_ST_PHASE_SET] == $past(multiframe_phase_set_flag))
        else $error("phase flag read wrong");
    reserved_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && sel_status |=> !reg_rdata[7] && !reg_rdata[1])
        else $error("reserved status bits not zero");

    // channel outputs
    chan_a_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        first_pair_enable |=> chan_a_en)
        else $error("channel a not enabled");
    chan_a_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !first_pair_enable |=> !chan_a_en)
        else $error("channel a not disabled");
    chan_b_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        first_pair_enable && !one_ch |=> chan_b_en)
        else $error("channel b not enabled");
    chan_cd_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        second_pair_enable && !one_ch |=> chan_c_en && chan_d_en)
        else $error("channels c d not enabled");
    chan_cd_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !second_pair_enable |=> !chan_c_en && !chan_d_en)
        else $error("channels c d not disabled");
    one_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        one_ch |=> one_channel_mode)
        else $error("single channel mode not shown");
    full_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !one_ch |=> !one_channel_mode)
        else $error("single channel mode shown wrongly");

    // link shape
    lanes_half_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pair_off |=> link_lanes == 8'((LANES_FULL + 1) / 2))
        else $error("lane count not halved");
    lanes_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !pair_off |=> link_lanes == 8'(LANES_FULL))
        else $error("lane count not full");
    conv_full_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !pair_off |=> link_converters == 8'(CONV_FULL))
        else $error("converter count not full");
    conv_one_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        one_ch |=> link_converters == 8'(CONV_FULL / 2))
        else $error("converter count not halved in single mode");
    first_off_scale_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !first_pair_enable |=> link_converters == 8'(CONV_FULL / 2))
        else $error("converter count not halved for first pair off");
    tail_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        pair_off && (LANES_FULL % 2 == 1) |=> tail_pad_en)
        else $error("tail padding missing");
    tail_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !pair_off |=> !tail_pad_en)
        else $error("tail padding in full mode");
    tail_even_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (LANES_FULL % 2 == 0) |-> !tail_pad_en)
        else $error("tail padding with even lane count");
    place_normal_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        first_pair_enable |=> !sample_place_shift)
        else $error("sample placement shifted wrongly");
endmodule

// *** verif/lsce_rx_model.sv ***
`timescale 1ns/1ns
// receiver model: sync request line and link-up level
module lsce_rx_model (
    // clock
    input wire logic clk_sys,
    // bench request to resynchronise
    input wire logic resync,
    // link side
    output logic sync_line_n,
    output logic link_up
);
    // link is up only a cycle after sync is released, never at once
    always_ff @(posedge clk_sys) begin
        sync_line_n <= !resync;
        link_up <= !resync && sync_line_n;
    end
endmodule

// *** verif/test_link_status_channel_enable.sv ***
`timescale 1ns/1ns
// self-checking bench for the status and channel enable block
module test_link_status_channel_enable;
    import lsce_pkg::*;
    localparam int unsigned NL = 5;
    localparam int unsigned NC = 4;
    logic clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_seen = 0, resync = 1;
    logic realign = 0, event_p = 0, jen = 0, spl = 0, cpl = 0;
    logic sync_line_n, link_up, ca, cb, cc, cd, one, tail, shift;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, lanes, conv;
    logic [15:0] n;
    logic [15:0] expq[$];
    // reserved bits written as zero, pair enables never both cleared
    logic [7:0] cv [5] = '{8'h01, 8'h02, 8'h07, 8'h05, 8'h03};
    int miscompares = 0, comparisons = 0, seed = 80;
    always #4 clk_sys = !clk_sys;
    lsce_rx_model rx (.clk_sys(clk_sys), .resync(resync), .sync_line_n(sync_line_n),
        .link_up(link_up));
    lsce_top #(.LANES_FULL(NL), .CONV_FULL(NC)) dut (.clk_sys(clk_sys), .rstn(rstn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sync_line_n(sync_line_n), .sysref_realign(realign),
        .sysref_event(event_p), .serial_link_enable_bit(jen), .serializer_pll_lock(spl),
        .sampling_pll_lock(cpl), .link_up(link_up), .chan_a_en(ca), .chan_b_en(cb),
        .chan_c_en(cc), .chan_d_en(cd), .one_channel_mode(one), .link_lanes(lanes),
        .link_converters(conv), .tail_pad_en(tail), .sample_place_shift(shift));
    task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one cycle of the register port; a read notes {mask, expected}
    task acc(input logic w, input logic r, input logic [11:0] a, input logic [7:0] d,
        input logic [15:0] em);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        if (r) expq.push_back(em);
        @(posedge clk_sys);
    endtask
    task wr(input logic [11:0] a, input logic [7:0] d);
        acc(1, 0, a, d, 0);
        acc(0, 0, a, 0, 0);
    endtask
    task rd(input logic [11:0] a, input logic [15:0] em);
        acc(0, 1, a, 0, em);
        acc(0, 0, a, 0, 0);
    endtask
    // reserved status bits 7 and 1 are left out of the mask
    task rs(input logic rl, input logic al);
        rd(LSCE_OFS_STATUS, {8'h7d, 1'b0, link_up, sync_line_n, rl, al, spl, 1'b0, cpl});
    endtask
    task chk_ch(input logic [7:0] v);
        logic off;
        off = !v[0] || !v[1] || v[2];
        cmp("chan", {v[0], v[0] && !v[2], v[1] && !v[2], v[1] && !v[2], v[2], off && NL[0],
            !v[0], off ? 8'((NL + 1) / 2) : 8'(NL), off ? 8'(NC / 2) : 8'(NC)},
            {ca, cb, cc, cd, one, tail, shift, lanes, conv});
    endtask
    task summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys) rd_seen <= reg_rd;
    // read data stand only in the cycle after the strobe
    always @(negedge clk_sys) begin
        if (rd_seen) begin
            n = expq.pop_front();
            cmp("rdata", n[7:0] & n[15:8], reg_rdata & n[15:8]);
        end
    end
    initial begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1;
        repeat (4) @(posedge clk_sys);
        chk_ch(8'h03);
        rd(LSCE_OFS_CHEN, 16'hff03);
        $display("reset test done");
        for (int i = 0; i < 6; i++) begin
            {resync, spl, cpl} <= 3'($random(seed));
            repeat (3) @(posedge clk_sys);
            rs(0, 0);
            wr(LSCE_OFS_STATUS, 8'hff);
            rs(0, 0);
        end
        $display("live test done");
        realign <= 1;
        event_p <= 1;
        @(posedge clk_sys);
        realign <= 0;
        event_p <= 0;
        rs(1, 0);
        wr(LSCE_OFS_STATUS, 8'h08);
        rs(1, 0);
        wr(LSCE_OFS_STATUS, 8'h10);
        rs(0, 0);
        jen <= 1;
        repeat (2) @(posedge clk_sys);
        event_p <= 1;
        @(posedge clk_sys);
        event_p <= 0;
        rs(0, 1);
        wr(LSCE_OFS_STATUS, 8'hef);
        rs(0, 0);
        jen <= 0;
        $display("sticky test done");
        foreach (cv[i]) begin
            wr(LSCE_OFS_CHEN, cv[i]);
            @(posedge clk_sys);
            chk_ch(cv[i]);
            rd(LSCE_OFS_CHEN, {8'hff, cv[i]});
        end
        acc(1, 0, LSCE_OFS_CHEN, 8'h02, 0);
        acc(0, 1, LSCE_OFS_CHEN, 0, 16'hff02);
        wr(12'h20a, 8'hff);
        rd(12'h20a, 16'hff00);
        rd(LSCE_OFS_CHEN, 16'hff02);
        $display("channel test done");
        repeat (3) @(posedge clk_sys);
        cmp("rdq", 0, expq.size());
        summarize();
    end
endmodule
